// ---- logic/axis_encoder_motor_setup.sv ----
// Per-axis encoder decoding, capture and motor parameter store with AHB-Lite access
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
module axis_encoder_motor_setup #(
	parameter int unsigned NENC = axis_setup_pkg::NUM_ENC,   // Encoder inputs
	parameter int unsigned NMOT = axis_setup_pkg::NUM_MOTOR  // Motors
) (
	input  wire logic                      hclk,       // Clock 250 MHz
	input  wire logic                      hresetn,    // Async reset, low
	input  wire logic                      hsel,       // Slave select
	input  wire logic [31:0]               haddr,      // Byte address
	input  wire logic [1:0]                htrans,     // Transfer type
	input  wire logic                      hwrite,     // Write when high
	input  wire logic [2:0]                hsize,      // Transfer size
	input  wire logic [31:0]               hwdata,     // Write data
	input  wire logic                      hready,     // Bus ready in
	output logic                           hreadyout,  // Slave ready
	output logic                           hresp,      // Always OKAY
	output logic [31:0]                    hrdata,     // Read data
	input  wire axis_setup_pkg::enc_pins_t enc_pins [NENC], // Encoder pins, async
	output axis_setup_pkg::nv_req_t        nv_req,     // Nonvolatile request
	input  wire logic [23:0]               nv_rdata,   // Nonvolatile data, next cycle
	output logic [NMOT-1:0]                motor_run,  // Servo processed
	output logic [NMOT-1:0]                motor_commutate, // Two-output mode
	output logic [NMOT-1:0]                motor_dir_mode,  // Enable line is direction
	output logic [NMOT-1:0]                motor_search_en  // Phase search at power-up
);

	localparam int unsigned NP = axis_setup_pkg::NUM_PARAMS;

	// Working parameter memory
	logic [23:0] param_r [NP];
	logic [7:0]  index_r;
	logic        busy_r;
	logic        loaded_r;
	logic        storing_r;
	logic [7:0]  nv_ptr_r;
	logic [7:0]  nv_wait_r;
	logic        nv_rd_pend_r;

	// Reset value of one parameter slot
	function automatic logic [23:0] param_default(input int unsigned idx);
		int unsigned m;
		m = 0;
		if (idx < axis_setup_pkg::MOTOR_BASE) begin
			unique case (3'(idx % axis_setup_pkg::ENC_PARAMS))
				axis_setup_pkg::EP_DECODE:     return axis_setup_pkg::DECODE_RST;    // R4
				axis_setup_pkg::EP_FILTER_DIS: return axis_setup_pkg::FILTER_RST;    // R6
				axis_setup_pkg::EP_CAPT_TRIG:  return axis_setup_pkg::CAPT_TRIG_RST; // R8
				axis_setup_pkg::EP_CAPT_FLAG:  return axis_setup_pkg::CAPT_FLAG_RST; // R9
				default:                       return axis_setup_pkg::ZERO_RST;
			endcase
		end
		m = (idx - axis_setup_pkg::MOTOR_BASE) / axis_setup_pkg::MOTOR_PARAMS;
		unique case (4'((idx - axis_setup_pkg::MOTOR_BASE) % axis_setup_pkg::MOTOR_PARAMS))
			axis_setup_pkg::MP_ACTIVATE:    return axis_setup_pkg::ACTIVATE_RST;
			axis_setup_pkg::MP_COMMUT_EN:   return axis_setup_pkg::COMMUT_RST;    // R12
			axis_setup_pkg::MP_OUT_ADDR:    return axis_setup_pkg::OUT_ADDR_RST;  // R19
			// Encoder 2x-1 phase register; each encoder spans four addresses
			axis_setup_pkg::MP_FB_ADDR:     return axis_setup_pkg::FB_ADDR_BASE
				+ 24'(m) * axis_setup_pkg::FB_ADDR_STEP;                       // R14
			axis_setup_pkg::MP_CYC_MULT:    return axis_setup_pkg::CYC_MULT_RST;  // R15
			axis_setup_pkg::MP_CYC_COUNTS:  return axis_setup_pkg::CYC_CNT_RST;   // R15
			axis_setup_pkg::MP_PHASE_ANGLE: return axis_setup_pkg::PHASE_RST;     // R16
			axis_setup_pkg::MP_SEARCH_MAG:  return axis_setup_pkg::SRCH_MAG_RST;  // R17
			axis_setup_pkg::MP_SEARCH_TIME: return axis_setup_pkg::SRCH_TIME_RST; // R17
			default:                        return axis_setup_pkg::ZERO_RST;
		endcase
	endfunction

	// Parameter index of encoder e slot s
	function automatic int unsigned enc_idx(input int unsigned e, input logic [2:0] s);
		return axis_setup_pkg::ENC_BASE + e * axis_setup_pkg::ENC_PARAMS + int'(s); // R2
	endfunction

	// Parameter index of motor m slot s
	function automatic int unsigned mot_idx(input int unsigned m, input logic [3:0] s);
		return axis_setup_pkg::MOTOR_BASE + m * axis_setup_pkg::MOTOR_PARAMS + int'(s); // R10
	endfunction

	// AHB address phase capture
	logic        ap_valid_r;
	logic        ap_write_r;
	logic [11:0] ap_addr_r;
	wire  logic  ap_take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r  <= 12'h000;
		end else if (hready) begin
			ap_valid_r <= ap_take;
			ap_write_r <= hwrite;
			ap_addr_r  <= haddr[11:0];
		end
	end

	// Zero wait states; response is always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	wire logic wr_now = ap_valid_r && ap_write_r;
	wire logic ctrl_wr = wr_now && ap_addr_r == axis_setup_pkg::A_CONTROL;
	// Data writes refused while busy, keeping the stored copy coherent
	wire logic data_wr = wr_now && ap_addr_r == axis_setup_pkg::A_PARAM_DATA && !busy_r;

	// Index register selects the named parameter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			index_r <= 8'h00;
		end else if (wr_now && ap_addr_r == axis_setup_pkg::A_PARAM_INDEX) begin
			index_r <= hwdata[7:0]; // R20
		end
	end

	// Nonvolatile sequencer: power-up load, store on command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_r       <= 1'b1;
			loaded_r     <= 1'b0;
			storing_r    <= 1'b0;
			nv_ptr_r     <= 8'h00;
			nv_wait_r    <= 8'h00;
			nv_rd_pend_r <= 1'b0;
			nv_req       <= '0;
		end else begin
			nv_req.rd    <= 1'b0;
			nv_req.wr    <= 1'b0;
			nv_rd_pend_r <= nv_req.rd;
			if (!busy_r) begin
				if (ctrl_wr && hwdata[axis_setup_pkg::CTRL_STORE]) begin
					busy_r    <= 1'b1; // R1
					storing_r <= 1'b1;
					nv_ptr_r  <= 8'h00;
					nv_wait_r <= 8'h00;
				end else if (ctrl_wr && hwdata[axis_setup_pkg::CTRL_LOAD]) begin
					busy_r    <= 1'b1;
					storing_r <= 1'b0;
					nv_ptr_r  <= 8'h00;
					nv_wait_r <= 8'h00;
				end
			end else if (nv_wait_r != 8'h00) begin
				nv_wait_r <= nv_wait_r - 8'h01;
			end else begin
				nv_req.addr  <= nv_ptr_r;
				nv_req.wdata <= param_r[nv_ptr_r];
				nv_req.wr    <= storing_r;  // R1
				nv_req.rd    <= !storing_r; // R1
				nv_wait_r    <= 8'(axis_setup_pkg::NV_WORD_CYC);
				if (nv_ptr_r == 8'(NP - 1)) begin
					busy_r   <= 1'b0;
					loaded_r <= 1'b1;
				end
				nv_ptr_r <= nv_ptr_r + 8'h01;
			end
		end
	end

	// Load data lands one cycle after the read request
	logic [7:0] nv_land_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nv_land_r <= 8'h00;
		end else begin
			nv_land_r <= nv_req.addr;
		end
	end

	// Working memory: defaults at reset, then load or host write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NP; i++) begin
				param_r[i] <= param_default(i);
			end
		end else if (nv_rd_pend_r) begin
			param_r[nv_land_r] <= nv_rdata; // R1
		end else if (data_wr && index_r < 8'(NP)) begin
			param_r[index_r] <= hwdata[23:0]; // R20
		end
	end

	// Encoder pin synchronisers, two stages
	axis_setup_pkg::enc_pins_t sync1_r [NENC];
	axis_setup_pkg::enc_pins_t sync2_r [NENC];
	axis_setup_pkg::enc_pins_t filt_r  [NENC];
	axis_setup_pkg::enc_pins_t cand_r  [NENC];
	axis_setup_pkg::enc_pins_t prev_r  [NENC];
	logic [1:0]                agree_r [NENC];
	logic [23:0]               pos_r   [NENC];
	logic [23:0]               capt_r  [NENC];
	logic [NENC-1:0]           capt_flag_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int e = 0; e < NENC; e++) begin
				sync1_r[e] <= '0;
				sync2_r[e] <= '0;
			end
		end else begin
			for (int e = 0; e < NENC; e++) begin
				sync1_r[e] <= enc_pins[e];
				sync2_r[e] <= sync1_r[e];
			end
		end
	end

	// Delay filter: a level must hold four samples; spikes shorter are dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int e = 0; e < NENC; e++) begin
				filt_r[e]  <= '0;
				cand_r[e]  <= '0;
				agree_r[e] <= 2'h0;
			end
		end else begin
			for (int e = 0; e < NENC; e++) begin
				cand_r[e] <= sync2_r[e];
				if (param_r[enc_idx(e, axis_setup_pkg::EP_FILTER_DIS)] != 24'h000000) begin
					filt_r[e]  <= sync2_r[e]; // R6
					agree_r[e] <= 2'h0;
				end else if (sync2_r[e] != cand_r[e]) begin
					agree_r[e] <= 2'h0;
				end else if (agree_r[e] == 2'h2) begin
					filt_r[e] <= cand_r[e]; // R6
				end else begin
					agree_r[e] <= agree_r[e] + 2'h1;
				end
			end
		end
	end

	// Quadrature / pulse-direction decode into a step
	function automatic axis_setup_pkg::count_step_t decode_step(
		input axis_setup_pkg::enc_pins_t cur,
		input axis_setup_pkg::enc_pins_t old,
		input logic [23:0]               sel
	);
		axis_setup_pkg::decode_t mode;
		logic                    fwd;
		logic                    ea;
		logic                    eb;
		logic                    cw;
		logic                    hit;
		axis_setup_pkg::count_step_t s;
		s   = '0;
		ea  = cur.a ^ old.a;
		eb  = cur.b ^ old.b;
		// Direction of a quadrature transition, A leading B is forward
		fwd = ea ? (cur.a ^ cur.b) : !(cur.a ^ cur.b);
		// Bit 2 selects counting sense: 7 and 3 are mirror x4 modes
		cw  = !sel[2]; // R5
		mode = axis_setup_pkg::decode_t'(sel[1:0]);
		hit  = 1'b0;
		unique case (mode)
			axis_setup_pkg::DEC_X1:    hit = ea && cur.a;
			axis_setup_pkg::DEC_X2:    hit = ea;
			axis_setup_pkg::DEC_X4:    hit = (ea ^ eb);
			axis_setup_pkg::DEC_PULSE: hit = 1'b0;
		endcase
		if (mode == axis_setup_pkg::DEC_PULSE) begin
			// A is pulse, B is direction
			s.up   = ea && cur.a && !cur.b;
			s.down = ea && cur.a && cur.b;
		end else begin
			s.up   = hit && (fwd ^ cw); // R3
			s.down = hit && !(fwd ^ cw); // R3
		end
		if (cw && mode == axis_setup_pkg::DEC_PULSE) begin
			s = {s.down, s.up};
		end
		return s;
	endfunction

	// Capture trigger: index, flag, or index and flag combined
	function automatic logic trig_level(
		input axis_setup_pkg::enc_pins_t p,
		input logic [23:0]               ctl,
		input logic [23:0]               fsel
	);
		logic f;
		f = p.flags[fsel[1:0]]; // R9
		unique case (ctl[1:0])
			axis_setup_pkg::TRIG_INDEX: return p.index;         // R7
			axis_setup_pkg::TRIG_FLAG:  return f;               // R7
			axis_setup_pkg::TRIG_BOTH:  return p.index && f;    // R7
			default:                    return 1'b0;
		endcase
	endfunction

	// Position counting and capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int e = 0; e < NENC; e++) begin
				prev_r[e] <= '0;
				pos_r[e]  <= 24'h000000;
				capt_r[e] <= 24'h000000;
			end
			capt_flag_r <= '0;
		end else begin
			for (int e = 0; e < NENC; e++) begin
				automatic axis_setup_pkg::count_step_t st;
				automatic logic [23:0] ctl;
				automatic logic [23:0] fs;
				automatic logic        t_now;
				automatic logic        t_old;
				automatic logic        edge_hit;
				st  = decode_step(filt_r[e], prev_r[e],
					param_r[enc_idx(e, axis_setup_pkg::EP_DECODE)]);
				ctl = param_r[enc_idx(e, axis_setup_pkg::EP_CAPT_TRIG)];
				fs  = param_r[enc_idx(e, axis_setup_pkg::EP_CAPT_FLAG)];
				t_now = trig_level(filt_r[e], ctl, fs);
				t_old = trig_level(prev_r[e], ctl, fs);
				// Bit 2 picks the falling edge instead of the rising one
				edge_hit = ctl[axis_setup_pkg::TRIG_FALL_BIT] ? (t_old && !t_now)
					: (!t_old && t_now);
				prev_r[e] <= filt_r[e];
				if (st.up) begin
					pos_r[e] <= pos_r[e] + 24'h000001;
				end else if (st.down) begin
					pos_r[e] <= pos_r[e] - 24'h000001;
				end
				if (edge_hit) begin
					capt_r[e]      <= pos_r[e]; // R21
					capt_flag_r[e] <= 1'b1;     // R21
				end else if (wr_now && ap_addr_r == axis_setup_pkg::A_STATUS
						&& hwdata[8 + e]) begin
					capt_flag_r[e] <= 1'b0;
				end
			end
		end
	end

	// Motor mode outputs follow the working parameters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			motor_run       <= '0;
			motor_commutate <= '0;
			motor_dir_mode  <= '0;
			motor_search_en <= '0;
		end else begin
			for (int m = 0; m < NMOT; m++) begin
				motor_run[m] <= !busy_r
					&& param_r[mot_idx(m, axis_setup_pkg::MP_ACTIVATE)] == 24'h000001; // R11
				motor_commutate[m] <= motor_run[m]
					&& param_r[mot_idx(m, axis_setup_pkg::MP_COMMUT_EN)] == 24'h000001; // R12
				motor_dir_mode[m] <= !param_r[mot_idx(m, axis_setup_pkg::MP_COMMUT_EN)][0]
					&& (param_r[mot_idx(m, axis_setup_pkg::MP_OUT_ADDR)]
					& axis_setup_pkg::SIGN_MAG_BIT) != 24'h000000; // R19
				motor_search_en[m] <= param_r[mot_idx(m, axis_setup_pkg::MP_COMMUT_EN)][0]
					&& param_r[mot_idx(m, axis_setup_pkg::MP_SLIP_GAIN)] == 24'h000000; // R18
			end
		end
	end

	// Read data mux, decoded in the address phase
	wire logic [11:0] rd_a = haddr[11:0];
	logic [31:0] rd_nxt;
	always_comb begin
		rd_nxt = 32'h00000000;
		unique case (1'b1)
			rd_a == axis_setup_pkg::A_PARAM_INDEX: rd_nxt = {24'h000000, index_r};
			rd_a == axis_setup_pkg::A_PARAM_DATA:
				rd_nxt = (index_r < 8'(NP)) ? {8'h00, param_r[index_r]} : 32'h00000000; // R20
			rd_a == axis_setup_pkg::A_STATUS:
				rd_nxt = {8'h00, capt_flag_r, 6'h00, loaded_r, busy_r};
			rd_a >= axis_setup_pkg::A_POS_BASE && rd_a < axis_setup_pkg::A_CAPT_BASE:
				rd_nxt = {8'h00, pos_r[rd_a[5:2]]};
			rd_a >= axis_setup_pkg::A_CAPT_BASE
				&& rd_a < axis_setup_pkg::A_CAPT_BASE + 12'h040:
				rd_nxt = {8'h00, capt_r[rd_a[5:2]]};
			default: rd_nxt = 32'h00000000;
		endcase
	end

	// Registered so read data stands through the whole data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else begin
			hrdata <= (ap_take && !hwrite) ? rd_nxt : 32'h00000000;
		end
	end

endmodule

// ---- logic/axis_setup_pkg.sv ----
// Constants and types for the per-axis encoder and motor setup block
// Operation
// [R1] Load parameters from nonvolatile store at power-up; write back only on store command
// [R2] Five encoder parameters per encoder, sixteen encoders in consecutive groups
// [R3] Decode x1, x2, x4 quadrature or pulse-and-direction; mode defines one count
// [R4] Decode selector resets to counterclockwise x4 value seven
// [R5] Changing x4 selector from seven to three reverses count direction
// [R6] Digital delay filter per input; zero keeps it, nonzero bypasses
// [R7] Capture trigger is index edge, flag edge, or edge of combination
// [R8] Capture control resets to one, rising edge of index channel
// [R9] Flag select chooses capture flag; zero selects home switch input
// [R10] Up to eight motors, each with its own parameter block
// [R11] Motor is processed only while activation parameter equals one
// [R12] Commutation enable one drives two outputs; zero default drives one
// [R13] Commutated motor output address is lower of consecutive output pair
// [R14] Commutation feedback defaults to phase register of encoder 2x-1
// [R15] Commutation cycle given as integer counts with integer multiplier
// [R16] Phase angle in 1/256 cycle; alternate value reverses polarity
// [R17] Phase search magnitude and half time, 8192 is quarter scale
// [R18] Nonzero slip gain suppresses phase search; magnetization current applied
// [R19] Non-commutated output address defaults 49155; sign-magnitude variant drives direction
// [R20] Host reads a parameter by name and writes it with a value
// [R21] On capture trigger edge, latch encoder count into capture register
package axis_setup_pkg;

	localparam int unsigned NUM_ENC       = 16;
	localparam int unsigned NUM_MOTOR     = 8;
	localparam int unsigned ENC_PARAMS    = 5;
	localparam int unsigned MOTOR_PARAMS  = 16;
	// Parameter index space: encoders first, then motors
	localparam int unsigned ENC_BASE      = 0;
	localparam int unsigned MOTOR_BASE    = NUM_ENC * ENC_PARAMS;
	localparam int unsigned NUM_PARAMS    = MOTOR_BASE + NUM_MOTOR * MOTOR_PARAMS;

	// Encoder parameter slots
	localparam logic [2:0] EP_DECODE      = 3'h0;
	localparam logic [2:0] EP_FILTER_DIS  = 3'h1;
	localparam logic [2:0] EP_CAPT_TRIG   = 3'h2;
	localparam logic [2:0] EP_CAPT_FLAG   = 3'h3;
	localparam logic [2:0] EP_SPARE       = 3'h4;
	// Motor parameter slots
	localparam logic [3:0] MP_ACTIVATE    = 4'h0;
	localparam logic [3:0] MP_COMMUT_EN   = 4'h1;
	localparam logic [3:0] MP_OUT_ADDR    = 4'h2;
	localparam logic [3:0] MP_FB_ADDR     = 4'h3;
	localparam logic [3:0] MP_CYC_MULT    = 4'h4;
	localparam logic [3:0] MP_CYC_COUNTS  = 4'h5;
	localparam logic [3:0] MP_PHASE_ANGLE = 4'h6;
	localparam logic [3:0] MP_SEARCH_MAG  = 4'h7;
	localparam logic [3:0] MP_SEARCH_TIME = 4'h8;
	localparam logic [3:0] MP_MAG_CURRENT = 4'h9;
	localparam logic [3:0] MP_SLIP_GAIN   = 4'ha;

	// Reset values
	localparam logic [23:0] DECODE_RST    = 24'h000007;
	localparam logic [23:0] DECODE_REV_X4 = 24'h000003;
	localparam logic [23:0] FILTER_RST    = 24'h000000;
	localparam logic [23:0] CAPT_TRIG_RST = 24'h000001;
	localparam logic [23:0] CAPT_FLAG_RST = 24'h000000;
	localparam logic [23:0] ACTIVATE_RST  = 24'h000001;
	localparam logic [23:0] COMMUT_RST    = 24'h000000;
	localparam logic [23:0] OUT_ADDR_RST  = 24'h00c003;
	localparam logic [23:0] FB_ADDR_BASE  = 24'h00c001;
	localparam logic [23:0] FB_ADDR_STEP  = 24'h000008;
	localparam logic [23:0] CYC_MULT_RST  = 24'h000001;
	localparam logic [23:0] CYC_CNT_RST   = 24'h001388;
	localparam logic [23:0] PHASE_RST     = 24'h000055;
	localparam logic [23:0] SRCH_MAG_RST  = 24'h002000;
	localparam logic [23:0] SRCH_TIME_RST = 24'h000005;
	localparam logic [23:0] ZERO_RST      = 24'h000000;
	localparam logic [23:0] SIGN_MAG_BIT  = 24'h010000;

	// AHB register map (byte addresses)
	localparam logic [11:0] A_PARAM_INDEX = 12'h000;
	localparam logic [11:0] A_PARAM_DATA  = 12'h004;
	localparam logic [11:0] A_CONTROL     = 12'h008;
	localparam logic [11:0] A_STATUS      = 12'h00c;
	localparam logic [11:0] A_POS_BASE    = 12'h100;
	localparam logic [11:0] A_CAPT_BASE   = 12'h140;
	localparam int unsigned CTRL_STORE    = 0;
	localparam int unsigned CTRL_LOAD     = 1;
	localparam int unsigned ST_BUSY       = 0;
	localparam int unsigned ST_LOADED     = 1;

	// Nonvolatile store timing
	localparam int unsigned NV_WORD_NS    = 40;
	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned NV_WORD_CYC   = (NV_WORD_NS * CLK_MHZ + 999) / 1000;

	// Capture trigger encoding, low two bits pick the source
	localparam logic [1:0] TRIG_INDEX     = 2'h1;
	localparam logic [1:0] TRIG_FLAG      = 2'h2;
	localparam logic [1:0] TRIG_BOTH      = 2'h3;
	localparam int unsigned TRIG_FALL_BIT = 2;

	typedef enum logic [1:0] {
		DEC_X1,
		DEC_X2,
		DEC_PULSE,
		DEC_X4
	} decode_t;

	typedef struct packed {
		logic a;
		logic b;
		logic index;
		logic [3:0] flags;
	} enc_pins_t;

	typedef struct packed {
		logic        up;
		logic        down;
	} count_step_t;

	// Nonvolatile port request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [23:0] wdata;
	} nv_req_t;

endpackage

// ---- sim/axis_setup_chk.sv ----
// Assertions on the setup block ports
`timescale 1ns/1ps
module axis_setup_chk #(
	parameter int unsigned NMOT = 8 // Motors
) (
	input wire logic                    hclk,            // Clock
	input wire logic                    hresetn,         // Reset, low
	input wire logic                    hsel,            // Select
	input wire logic [31:0]             haddr,           // Address
	input wire logic [1:0]              htrans,          // Transfer type
	input wire logic                    hwrite,          // Write
	input wire logic [31:0]             hwdata,          // Write data
	input wire logic                    hready,          // Bus ready
	input wire logic                    hreadyout,       // Slave ready
	input wire logic                    hresp,           // Response
	input wire logic [31:0]             hrdata,          // Read data
	input wire axis_setup_pkg::nv_req_t nv_req,          // Store request
	input wire logic [NMOT-1:0]         motor_commutate, // Two outputs
	input wire logic [NMOT-1:0]         motor_dir_mode   // Direction line
);
	logic [11:0] a_q;
	logic        rd_q, wr_q, store_seen_r, rd_seen_r;
	logic [7:0]  last_r;
	logic [3:0]  cyc_r;
	wire         unmapped = (a_q >= 12'h010 && a_q < 12'h100) || a_q >= 12'h180;
	wire         tk = hsel && hready && htrans[1];

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Data phase tracking and store command seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_q <= 12'h000;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			store_seen_r <= 1'b0;
			rd_seen_r <= 1'b0;
			last_r <= 8'h00;
			cyc_r <= 4'h0;
		end else begin
			rd_q <= tk && !hwrite;
			wr_q <= tk && hwrite;
			if (tk)
				a_q <= haddr[11:0];
			if (wr_q && a_q == axis_setup_pkg::A_CONTROL && hwdata[0])
				store_seen_r <= 1'b1;
			if (nv_req.rd) begin
				last_r <= nv_req.addr;
				rd_seen_r <= 1'b1;
			end
			if (cyc_r != 4'hf)
				cyc_r <= cyc_r + 4'h1;
		end
	end

	sequence nv_quiet;
		(!nv_req.rd && !nv_req.wr) [*8];
	endsequence

	AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
	AST_NO_WAIT: assert property (hreadyout == 1'b1) else $error("wait state seen");
	AST_IDLE_RDATA: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata idle");
	AST_UNMAPPED_ZERO: assert property (rd_q && unmapped |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_LOAD_START: assert property (cyc_r == 4'h1 |-> ##[0:30] nv_req.rd)
		else $error("no power-up load");
	AST_NV_GAP: assert property (nv_req.rd || nv_req.wr |=> nv_quiet)
		else $error("requests too close");
	AST_NV_ORDER: assert property (nv_req.rd && rd_seen_r |->
		nv_req.addr == last_r + 8'h01 || nv_req.addr == 8'h00) else $error("load order");
	AST_WR_NEEDS_STORE: assert property (nv_req.wr |-> store_seen_r)
		else $error("write without store");
	AST_NO_RDWR: assert property (!(nv_req.rd && nv_req.wr)) else $error("read and write");
	AST_DIR_MODE: assert property ((motor_dir_mode & motor_commutate) == '0)
		else $error("dir while commutating");
endmodule

bind axis_encoder_motor_setup axis_setup_chk #(.NMOT(NMOT)) chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .nv_req(nv_req),
	.motor_commutate(motor_commutate), .motor_dir_mode(motor_dir_mode));

// ---- sim/axis_far_model.sv ----
// Nonvolatile store and encoder model
`timescale 1ns/1ps
module axis_far_model (
	input  wire logic                    hclk,      // Clock
	input  wire axis_setup_pkg::nv_req_t nv_req,    // Store request
	output logic [23:0]                  nv_rdata,  // Store data
	input  wire logic                    step,      // One quadrature edge
	input  wire logic                    index_lvl, // Index channel
	input  wire logic                    home_lvl,  // Home switch
	output axis_setup_pkg::enc_pins_t    enc_pins [16] // Encoder pins
);
	logic [23:0] mem [208];
	int          wr_cnt = 0;
	logic [1:0]  ph = 2'h0;

	// Store preloaded with defaults of encoder zero and motor zero, motor slots 0 to 3 only; the rest zero
	initial begin
		nv_rdata = 24'h5a5a5a;
		mem = '{default: 24'h000000};
		mem[0] = axis_setup_pkg::DECODE_RST;
		mem[2] = axis_setup_pkg::CAPT_TRIG_RST;
		mem[80] = axis_setup_pkg::ACTIVATE_RST;
		mem[82] = axis_setup_pkg::OUT_ADDR_RST;
		mem[83] = axis_setup_pkg::FB_ADDR_BASE;
	end

	// Data valid the cycle after a read, scrambled otherwise
	always @(posedge hclk) begin
		nv_rdata <= nv_req.rd ? mem[nv_req.addr] : ~nv_rdata;
		if (nv_req.wr) begin
			mem[nv_req.addr] <= nv_req.wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (step)
			ph <= ph + 2'h1;
	end

	// Quadrature on encoder zero only
	always_comb begin
		foreach (enc_pins[i])
			enc_pins[i] = '0;
		enc_pins[0].a = ph[1];
		enc_pins[0].b = ph[1] ^ ph[0];
		enc_pins[0].index = index_lvl;
		enc_pins[0].flags = {3'h0, home_lvl};
	end
endmodule

// ---- sim/axis_encoder_motor_setup_tb.sv ----
// Bench for the encoder and motor setup block
`timescale 1ns/1ps
module axis_encoder_motor_setup_tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
	logic        step = 1'b0, idx_lvl = 1'b0, home_lvl = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv, p1;
	logic        hreadyout, hresp;
	logic [31:0] hrdata;
	logic [23:0] nv_rdata, d;
	logic [7:0]  run, com, dir, srch;
	logic [23:0] md [3] = '{24'h4, 24'h5, 24'h7};
	int          bad_count = 0, cmp_count = 0;

	axis_setup_pkg::enc_pins_t enc_pins [16];
	axis_setup_pkg::nv_req_t   nv_req;

	always #2 hclk = ~hclk;

	axis_encoder_motor_setup uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enc_pins(enc_pins),
		.nv_req(nv_req), .nv_rdata(nv_rdata), .motor_run(run), .motor_commutate(com),
		.motor_dir_mode(dir), .motor_search_en(srch));
	axis_far_model far (.hclk(hclk), .nv_req(nv_req), .nv_rdata(nv_rdata), .step(step),
		.index_lvl(idx_lvl), .home_lvl(home_lvl), .enc_pins(enc_pins));

	// Single AHB transfer, read data to rdv
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd = 32'h0);
		@(posedge hclk);
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wp(input int i, input logic [23:0] v);
		xfer(axis_setup_pkg::A_PARAM_INDEX, 1'b1, 32'(i));
		xfer(axis_setup_pkg::A_PARAM_DATA, 1'b1, {8'h0, v});
		repeat (3) @(posedge hclk);
	endtask
	task rp(input int i, input logic [23:0] e);
		xfer(axis_setup_pkg::A_PARAM_INDEX, 1'b1, 32'(i));
		xfer(axis_setup_pkg::A_PARAM_DATA, 1'b0);
		chk({8'h0, rdv[23:0]}, {8'h0, e});
	endtask
	// Poll until load or store ends
	task wait_idle();
		do xfer(axis_setup_pkg::A_STATUS, 1'b0);
		while (rdv[axis_setup_pkg::ST_BUSY] !== 1'b0);
	endtask
	// Spaced so the filter passes each edge
	task move(input int n);
		xfer(axis_setup_pkg::A_POS_BASE, 1'b0);
		p1 = rdv;
		repeat (n) begin
			@(posedge hclk) step <= 1'b1;
			@(posedge hclk) step <= 1'b0;
			repeat (8) @(posedge hclk);
		end
		xfer(axis_setup_pkg::A_POS_BASE, 1'b0);
		d = rdv[23:0] - p1[23:0];
	endtask
	// Clear flag, raise trigger, compare capture with position
	task capture(input logic use_home);
		xfer(axis_setup_pkg::A_STATUS, 1'b1, 32'h100);
		{home_lvl, idx_lvl} <= use_home ? 2'h2 : 2'h1;
		repeat (10) @(posedge hclk);
		xfer(axis_setup_pkg::A_POS_BASE, 1'b0);
		p1 = rdv;
		xfer(axis_setup_pkg::A_CAPT_BASE, 1'b0);
		chk(rdv, p1);
		xfer(axis_setup_pkg::A_STATUS, 1'b0);
		chk(32'(rdv[8]), 32'h1);
		{home_lvl, idx_lvl} <= 2'h0;
	endtask
	task print_verdict();
		$display("mismatches %0d comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		wait_idle();
		chk(32'(far.wr_cnt), 32'h0);
		rp(0, axis_setup_pkg::DECODE_RST);
		rp(1, axis_setup_pkg::FILTER_RST);
		rp(2, axis_setup_pkg::CAPT_TRIG_RST);
		rp(3, axis_setup_pkg::CAPT_FLAG_RST);
		rp(81, axis_setup_pkg::COMMUT_RST);
		rp(82, axis_setup_pkg::OUT_ADDR_RST);
		rp(83, axis_setup_pkg::FB_ADDR_BASE);
		chk(32'(run[0]), 32'h1);
		xfer(12'h020, 1'b0);
		chk(rdv, 32'h0);
		wp(75, 24'h5);
		rp(75, 24'h5);
		chk({8'h0, far.mem[75]}, 32'h0);
		xfer(axis_setup_pkg::A_CONTROL, 1'b1, 32'h1);
		wait_idle();
		chk({8'h0, far.mem[75]}, 32'h5);
		for (int k = 0; k < 3; k++) begin
			wp(0, md[k]);
			move(12);
			chk({8'h0, d}, {8'h0, 24'(-(3 << k))});
		end
		wp(0, axis_setup_pkg::DECODE_REV_X4);
		move(12);
		chk({8'h0, d}, 32'hc);
		capture(1'b0);
		wp(2, {22'h0, axis_setup_pkg::TRIG_FLAG});
		wp(3, 24'h0);
		move(4);
		capture(1'b1);
		wp(80, 24'h2);
		chk(32'(run[0]), 32'h0);
		wp(80, 24'h1);
		wp(81, 24'h1);
		chk(32'(com[0]), 32'h1);
		chk(32'(srch[0]), 32'h1);
		wp(90, 24'h9c4);
		chk(32'(srch[0]), 32'h0);
		wp(81, 24'h0);
		wp(82, 24'h1c003);
		chk(32'(dir[0]), 32'h1);
		print_verdict();
	end

	// Watchdog beyond load, store and traffic
	initial begin
		repeat (40000) @(posedge hclk);
		bad_count++;
		print_verdict();
	end
endmodule
